// >>> hdl/ialm_defs.svh
/*
 * constants of the input alarm threshold register bank: byte offsets,
 * field positions and reset values.
 * assumes it is included by bare name by the register bank design file.
 */
// Function
// - the upper-limit register spans byte addresses 24h to 27h, low byte first.
// - the lower-limit register spans byte addresses 28h to 2Bh, low byte first.
// - bits 31 to 24 of the upper-limit register hold a writable hysteresis reset to zero.
// - bits 23 to 16 of the upper-limit register are read-only and read zero.
// - bits 15 to 0 of the upper-limit register hold the high limit, reset to all ones.
// - bits 15 to 0 of the lower-limit register hold the low limit, reset to zero.
// - the upper sixteen bits of the lower-limit register are read-only and read zero.
// - a high-input alarm shows as active at status bit 10 and tripped at bit 4.
// - a low-input alarm shows as active at status bit 11 and tripped at bit 5.
// - status bit 0 is the OR of all tripped alarm flags.
`ifndef IALM_DEFS_SVH
`define IALM_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IALM_ADR_STATUS 8'h20
`define IALM_ADR_UPPER 8'h24
`define IALM_ADR_LOWER 8'h28
`define IALM_ADR_IRQ_STAT 8'h30
`define IALM_ADR_IRQ_MASK 8'h34

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IALM_ST_SUMMARY 0
`define IALM_ST_TRIP_HIGH 4
`define IALM_ST_TRIP_LOW 5
`define IALM_ST_ACT_HIGH 10
`define IALM_ST_ACT_LOW 11
`define IALM_IRQ_HIGH 0
`define IALM_IRQ_LOW 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IALM_RST_HYST 8'h00
`define IALM_RST_UPPER 16'hFFFF
`define IALM_RST_LOWER 16'h0000
`define IALM_RST_IRQ 2'h0

`endif

// >>> hdl/ialm_pkg.sv
/*
 * types of the input alarm threshold register bank: the state record
 * of each module.
 * assumes ialm_defs.svh is on the include path.
 */
package ialm_pkg;

    // ------------------------------------------------------------------
    // state records
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] q;
    } ialm_byte_st_t;

    typedef struct packed {
        logic active;
        logic trip_evt;
    } ialm_cmp_st_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic trip_high;
        logic trip_low;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
    } ialm_top_st_t;

endpackage

// >>> hdl/ialm_byte_reg.sv
/*
 * one writable byte of a register, loaded when its lane is written.
 * assumes the write strobe comes from logic on the same clock.
 */
`timescale 1ns/10ps
module ialm_byte_reg
    import ialm_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored byte
    output logic [7:0] q
);

    ialm_byte_st_t st_r;
    ialm_byte_st_t st_nxt;

    // load on a lane write, otherwise hold
    always_comb
    begin
        st_nxt = st_r;
        if (wr_en)
        begin
            st_nxt.q = wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '{q: RST_VAL};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;

endmodule

// >>> hdl/ialm_cmp.sv
/*
 * one alarm comparator with hysteresis; ABOVE selects the high or the
 * low direction. holds the active flag and pulses trip_evt when it rises.
 * assumes sample and limits come from logic on the same clock.
 */
`timescale 1ns/10ps
module ialm_cmp
    import ialm_pkg::*;
#(
    parameter bit ABOVE = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // conversion result
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    // thresholds
    input wire logic [15:0] limit,
    input wire logic [7:0] hyst,
    // alarm state
    output logic active,
    output logic trip_evt
);

    ialm_cmp_st_t st_r;
    ialm_cmp_st_t st_nxt;
    logic [16:0] s_ext;
    logic [16:0] l_ext;
    logic [16:0] h_ext;
    logic over;
    logic back;

    // 17-bit sums so limit plus hysteresis never wraps at full scale
    assign s_ext = {1'b0, sample};
    assign l_ext = {1'b0, limit};
    assign h_ext = {9'h0_00, hyst[7:2], 2'b00};
    assign over = ABOVE ? (s_ext > l_ext) : (s_ext < l_ext);
    assign back = ABOVE ? ((s_ext + h_ext) < l_ext) : (s_ext > (l_ext + h_ext));

    // alarm sets past the limit and clears only once back inside the band
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.trip_evt = 1'b0;
        if (sample_valid)
        begin
            if (over)
            begin
                st_nxt.active = 1'b1;
                st_nxt.trip_evt = ~st_r.active;
            end
            else if (back)
            begin
                st_nxt.active = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '{active: 1'b0, trip_evt: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign active = st_r.active;
    assign trip_evt = st_r.trip_evt;

endmodule

// >>> hdl/ialm_regs.sv
/*
 * input alarm threshold register bank: the upper-limit/hysteresis and
 * lower-limit registers, the alarm status word, and a masked interrupt,
 * all behind a classic wishbone slave with 32-bit data and byte addresses.
 * word map: 20h alarm status (read only), 24h upper limit and
 * hysteresis, 28h lower limit, 30h interrupt events (write one to
 * clear, lane 0), 34h interrupt mask (lane 0); other words read zero.
 * each access is answered one cycle after the request, every time.
 * assumes conversion results arrive from logic on the same clock, one
 * word per sample_valid pulse, and a single-cycle wishbone master.
 */
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`include "ialm_defs.svh"
module ialm_regs
    import ialm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // conversion results
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    // alarm outputs
    output logic alarm_high,
    output logic alarm_low,
    output logic any_alarm_summary,
    output logic irq
);

    // ------------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------------
    ialm_top_st_t st_r;
    ialm_top_st_t st_nxt;
    // threshold fields as stored
    logic [7:0] input_alarm_hysteresis;
    logic [15:0] input_alarm_upper_limit;
    logic [15:0] input_alarm_lower_limit;
    // alarm flags and events from the comparators
    logic act_high;
    logic act_low;
    logic evt_high;
    logic evt_low;
    // bus strobes and word selects
    logic req;
    logic wr_stb;
    logic rd_stb;
    logic sel_status;
    logic sel_upper;
    logic sel_lower;
    logic sel_irq_stat;
    logic sel_irq_mask;
    logic wr_irq_mask;
    logic wr_irq_stat;
    logic rd_status;
    // read words
    logic [31:0] upper_word;
    logic [31:0] lower_word;
    logic [31:0] status_word;
    logic [31:0] irq_stat_word;
    logic [31:0] irq_mask_word;
    logic [31:0] rd_word;
    // byte lane write enables
    logic wr_upper_b0;
    logic wr_upper_b1;
    logic wr_upper_b3;
    logic wr_lower_b0;
    logic wr_lower_b1;

    // ------------------------------------------------------------------
    // decode constants
    // ------------------------------------------------------------------

    // word indices of the mapped registers, byte address bits 7 to 2
    localparam logic [5:0] WORD_STATUS = 6'(`IALM_ADR_STATUS >> 2);
    localparam logic [5:0] WORD_UPPER = 6'(`IALM_ADR_UPPER >> 2);
    localparam logic [5:0] WORD_LOWER = 6'(`IALM_ADR_LOWER >> 2);
    localparam logic [5:0] WORD_IRQ_STAT = 6'(`IALM_ADR_IRQ_STAT >> 2);
    localparam logic [5:0] WORD_IRQ_MASK = 6'(`IALM_ADR_IRQ_MASK >> 2);

    // per-byte reset values; each limit is kept as two separate bytes
    localparam logic [7:0] UPPER_RST_LO = 8'(`IALM_RST_UPPER);
    localparam logic [7:0] UPPER_RST_HI = 8'(`IALM_RST_UPPER >> 8);
    localparam logic [7:0] LOWER_RST_LO = 8'(`IALM_RST_LOWER);
    localparam logic [7:0] LOWER_RST_HI = 8'(`IALM_RST_LOWER >> 8);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // a request is answered one cycle after it appears; the access itself
    // takes effect on the edge where the master sees ack high, and a
    // master that keeps stb up after ack gets a second access
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_stb = req & wb_we_i & st_r.ack;
    assign rd_stb = req & ~wb_we_i & st_r.ack;

    // word decode on the aligned address, low two bits ignored
    assign sel_status = (wb_adr_i[7:2] == WORD_STATUS);
    assign sel_upper = (wb_adr_i[7:2] == WORD_UPPER);
    assign sel_lower = (wb_adr_i[7:2] == WORD_LOWER);
    assign sel_irq_stat = (wb_adr_i[7:2] == WORD_IRQ_STAT);
    assign sel_irq_mask = (wb_adr_i[7:2] == WORD_IRQ_MASK);

    // byte lane strobes; lane 2 of either limit register has no storage
    assign wr_upper_b0 = wr_stb & sel_upper & wb_sel_i[0];
    assign wr_upper_b1 = wr_stb & sel_upper & wb_sel_i[1];
    assign wr_upper_b3 = wr_stb & sel_upper & wb_sel_i[3];
    assign wr_lower_b0 = wr_stb & sel_lower & wb_sel_i[0];
    assign wr_lower_b1 = wr_stb & sel_lower & wb_sel_i[1];

    // register-level strobes of the status read and the interrupt words
    assign rd_status = rd_stb & sel_status;
    assign wr_irq_mask = wr_stb & sel_irq_mask & wb_sel_i[0];
    assign wr_irq_stat = wr_stb & sel_irq_stat & wb_sel_i[0];

    // ------------------------------------------------------------------
    // threshold storage
    // ------------------------------------------------------------------

    // hysteresis byte in lane 3; the two low bits are stored as written,
    // since the host keeps them zero, but the comparators never use them
    ialm_byte_reg #(
        .RST_VAL(`IALM_RST_HYST)
    ) u_hyst (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_upper_b3),
        .wr_data(wb_dat_i[31:24]),
        .q(input_alarm_hysteresis)
    );

    // reserved lanes have no flip-flops: 26h, 2Ah and 2Bh simply read zero
    // high limit, low byte
    ialm_byte_reg #(
        .RST_VAL(UPPER_RST_LO)
    ) u_upper_lo (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_upper_b0),
        .wr_data(wb_dat_i[7:0]),
        .q(input_alarm_upper_limit[7:0])
    );

    // high limit, high byte
    ialm_byte_reg #(
        .RST_VAL(UPPER_RST_HI)
    ) u_upper_hi (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_upper_b1),
        .wr_data(wb_dat_i[15:8]),
        .q(input_alarm_upper_limit[15:8])
    );

    // low limit, low byte
    ialm_byte_reg #(
        .RST_VAL(LOWER_RST_LO)
    ) u_lower_lo (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_lower_b0),
        .wr_data(wb_dat_i[7:0]),
        .q(input_alarm_lower_limit[7:0])
    );

    // low limit, high byte
    ialm_byte_reg #(
        .RST_VAL(LOWER_RST_HI)
    ) u_lower_hi (
        .clk(clk),
        .nrst(nrst),
        .wr_en(wr_lower_b1),
        .wr_data(wb_dat_i[15:8]),
        .q(input_alarm_lower_limit[15:8])
    );

    // ------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------

    // both comparators see the same sample; each keeps its own band
    // high direction: alarm above the upper limit
    ialm_cmp #(
        .ABOVE(1'b1)
    ) u_cmp_high (
        .clk(clk),
        .nrst(nrst),
        .sample_valid(sample_valid),
        .sample(sample),
        .limit(input_alarm_upper_limit),
        .hyst(input_alarm_hysteresis),
        .active(act_high),
        .trip_evt(evt_high)
    );

    // low direction: alarm below the lower limit
    ialm_cmp #(
        .ABOVE(1'b0)
    ) u_cmp_low (
        .clk(clk),
        .nrst(nrst),
        .sample_valid(sample_valid),
        .sample(sample),
        .limit(input_alarm_lower_limit),
        .hyst(input_alarm_hysteresis),
        .active(act_low),
        .trip_evt(evt_low)
    );

    // ------------------------------------------------------------------
    // read words
    // ------------------------------------------------------------------

    // reserved middle byte of the upper register always reads zero
    assign upper_word = {input_alarm_hysteresis, 8'h00, input_alarm_upper_limit};
    // upper half of the lower register always reads zero
    assign lower_word = {16'h0000, input_alarm_lower_limit};
    // interrupt words carry their two event bits in lane 0 only
    assign irq_stat_word = {30'h0000_0000, st_r.irq_stat};
    assign irq_mask_word = {30'h0000_0000, st_r.irq_mask};

    // alarm status word, all other bits reserved zero; the active flags
    // follow the comparators, the tripped ones the latches below
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`IALM_ST_ACT_HIGH] = act_high;
        status_word[`IALM_ST_TRIP_HIGH] = st_r.trip_high;
        status_word[`IALM_ST_ACT_LOW] = act_low;
        status_word[`IALM_ST_TRIP_LOW] = st_r.trip_low;
        status_word[`IALM_ST_SUMMARY] = st_r.trip_high | st_r.trip_low;
    end

    // read mux; unmapped words answer with zero
    // decoded from the address alone, the capture edge decides what is read
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (sel_status)
        begin
            rd_word = status_word;
        end
        else if (sel_upper)
        begin
            rd_word = upper_word;
        end
        else if (sel_lower)
        begin
            rd_word = lower_word;
        end
        else if (sel_irq_stat)
        begin
            rd_word = irq_stat_word;
        end
        else if (sel_irq_mask)
        begin
            rd_word = irq_mask_word;
        end
    end

    // ------------------------------------------------------------------
    // bus answer, tripped flags and interrupt state
    // ------------------------------------------------------------------

    // tripped flags latch while the alarm is active and clear on a status
    // read; a still-active alarm re-sets in the same edge so nothing is lost
    always_comb
    begin
        st_nxt = st_r;
        // one-cycle ack; read data is captured with it and then stands
        st_nxt.ack = req & ~st_r.ack;
        if (req & ~st_r.ack)
        begin
            st_nxt.dat = rd_word;
        end

        // clear first, so an alarm that is still active sets the flag again
        if (rd_status)
        begin
            st_nxt.trip_high = 1'b0;
            st_nxt.trip_low = 1'b0;
        end
        if (act_high)
        begin
            st_nxt.trip_high = 1'b1;
        end
        if (act_low)
        begin
            st_nxt.trip_low = 1'b1;
        end

        // interrupt mask, lane 0 only
        if (wr_irq_mask)
        begin
            st_nxt.irq_mask = wb_dat_i[1:0];
        end

        // write-one-to-clear, then events set so a set wins the race
        if (wr_irq_stat)
        begin
            st_nxt.irq_stat = st_r.irq_stat & ~wb_dat_i[1:0];
        end
        if (evt_high)
        begin
            st_nxt.irq_stat[`IALM_IRQ_HIGH] = 1'b1;
        end
        if (evt_low)
        begin
            st_nxt.irq_stat[`IALM_IRQ_LOW] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '{ack: 1'b0, dat: 32'h0000_0000, trip_high: 1'b0, trip_low: 1'b0,
                      irq_stat: `IALM_RST_IRQ, irq_mask: `IALM_RST_IRQ};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // bus answer straight from the state record
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;

    // active flags come registered from the comparators
    assign alarm_high = act_high;
    assign alarm_low = act_low;
    assign any_alarm_summary = st_r.trip_high | st_r.trip_low;
    // level interrupt, high while any unmasked event bit is set
    assign irq = |(st_r.irq_stat & st_r.irq_mask);

endmodule

// >>> dv/ialm_regs_sva.sv
/*
 * port-level checker for the input alarm threshold register bank.
 * assumes one clock domain, clk, with the active-low asynchronous nrst.
 */
`timescale 1ns/10ps
module ialm_regs_sva (
    // clock and reset
    input logic clk,
    input logic nrst,
    // wishbone slave
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o,
    // conversion results
    input logic sample_valid,
    input logic [15:0] sample,
    // alarm outputs
    input logic alarm_high,
    input logic alarm_low,
    input logic any_alarm_summary,
    input logic irq
);
    // ------------------------------------------------------------------
    // bus steps
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // a request not yet answered, and the answer as a single pulse
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_read(w);
        s_req ##0 (!wb_we_i && wb_adr_i[7:2] == w);
    endsequence

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_ack_pulse: assert property (s_req |=> s_ack)
        else $error("ack not a one-cycle pulse after the request");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_upper_reserved: assert property (s_read(6'h09) |=> wb_dat_o[23:16] == 8'h00)
        else $error("upper register reserved byte not zero");
    a_lower_reserved: assert property (s_read(6'h0A) |=> wb_dat_o[31:16] == 16'h0000)
        else $error("lower register reserved half not zero");
    a_status_reserved: assert property (s_read(6'h08) |=> (wb_dat_o & 32'hFFFF_F3CE) == 0)
        else $error("status reserved bits not zero");
    a_high_summary: assert property ($rose(alarm_high) |=> any_alarm_summary)
        else $error("high alarm did not reach the summary");
    a_low_summary: assert property ($rose(alarm_low) |=> any_alarm_summary)
        else $error("low alarm did not reach the summary");
    // alarms move only on a compared sample, never on their own
    a_high_cause: assert property ($changed(alarm_high) |-> $past(sample_valid))
        else $error("high alarm changed without a sample");
    a_low_cause: assert property ($changed(alarm_low) |-> $past(sample_valid))
        else $error("low alarm changed without a sample");
endmodule

bind ialm_regs ialm_regs_sva u_sva (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_valid(sample_valid), .sample(sample), .alarm_high(alarm_high),
    .alarm_low(alarm_low), .any_alarm_summary(any_alarm_summary), .irq(irq));

// >>> dv/ialm_host_model.sv
/*
 * host controller model: a classic single-cycle wishbone master.
 * assumes the slave answers with ack and drives read data registered.
 */
`timescale 1ns/10ps
module ialm_host_model (
    // clock
    input logic clk,
    // wishbone master side
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [7:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o
);
    // idle bus at time zero
    initial
    begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
    end

    // one transfer; data is read in the active region, before the slave's update
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] dat, output logic [31:0] rdat);
        logic [31:0] d;
        d = (adr[7:2] == 6'h09 && sel[3]) ? (dat & 32'hFCFF_FFFF) : dat;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1)
            @(posedge clk);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_dat_i <= ~d; // released data must not look valid
    endtask
endmodule

// >>> dv/tb_ialm_regs.sv
/*
 * self-checking bench of the input alarm threshold register bank.
 * assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/10ps
module tb_ialm_regs;
    typedef struct packed {
        logic [7:0] wadr;
        logic [3:0] sel;
        logic [31:0] wdat;
        logic [7:0] radr;
        logic [31:0] exp;
    } ialm_row_t;
    // ------------------------------------------------------------------
    // write then read back, whole words and single lanes
    // ------------------------------------------------------------------
    localparam ialm_row_t ROWS [11] = '{
        '{8'h24, 4'hF, 32'hFFAB_1234, 8'h24, 32'hFC00_1234},
        '{8'h25, 4'h2, 32'h0000_7700, 8'h24, 32'hFC00_7734},
        '{8'h26, 4'h4, 32'h00FF_0000, 8'h24, 32'hFC00_7734},
        '{8'h27, 4'h8, 32'h4000_0000, 8'h24, 32'h4000_7734},
        '{8'h28, 4'hF, 32'h5A5A_0042, 8'h28, 32'h0000_0042},
        '{8'h29, 4'h2, 32'h0000_1100, 8'h28, 32'h0000_1142},
        '{8'h2B, 4'h8, 32'hFF00_0000, 8'h28, 32'h0000_1142},
        '{8'h20, 4'hF, 32'hFFFF_FFFF, 8'h20, 32'h0000_0000},
        '{8'h34, 4'hF, 32'hFFFF_FFFF, 8'h34, 32'h0000_0003},
        '{8'h30, 4'hF, 32'hFFFF_FFFF, 8'h30, 32'h0000_0000},
        '{8'h3C, 4'hF, 32'hFFFF_FFFF, 8'h3C, 32'h0000_0000}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sample_valid = 1'b0;
    logic [15:0] sample = 16'h0000;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, scratch;
    logic alarm_high, alarm_low, any_alarm_summary, irq;
    int errors = 0;
    int total_checks = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    ialm_host_model host (.clk(clk), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    ialm_regs uut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid),
        .sample(sample), .alarm_high(alarm_high), .alarm_low(alarm_low),
        .any_alarm_summary(any_alarm_summary), .irq(irq));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
        host.xfer(1'b1, adr, sel, d, scratch);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        host.xfer(1'b0, adr, 4'hF, 32'h0000_0000, scratch);
        chk(scratch, exp);
    endtask
    // flags as {alarm_high, alarm_low, summary, irq}, one edge after the cause lands
    task automatic flags(input logic [3:0] exp);
        @(posedge clk);
        #1;
        chk(32'({alarm_high, alarm_low, any_alarm_summary, irq}), 32'(exp));
    endtask
    // sample is taken one edge after it is driven; summary lands one edge after that
    task automatic samp(input logic [15:0] v, input logic [3:0] exp);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample <= v;
        @(posedge clk);
        sample_valid <= 1'b0;
        @(posedge clk);
        flags(exp);
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        foreach (ROWS[i])
        begin
            wr(ROWS[i].wadr, ROWS[i].sel, ROWS[i].wdat);
            rd_chk(ROWS[i].radr, ROWS[i].exp);
        end
        // mid-run reset brings back the field reset values
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(8'h24, 32'h0000_FFFF);
        rd_chk(8'h28, 32'h0000_0000);
        // upper 8000h with hysteresis 16, lower 1000h, both events unmasked
        wr(8'h24, 4'hF, 32'h1000_8000);
        wr(8'h28, 4'hF, 32'h0000_1000);
        wr(8'h34, 4'h1, 32'h0000_0003);
        samp(16'h8001, 4'hB);
        rd_chk(8'h20, 32'h0000_0411);
        samp(16'h7FF5, 4'hB);
        samp(16'h7FEF, 4'h3);
        rd_chk(8'h20, 32'h0000_0011);
        rd_chk(8'h20, 32'h0000_0000);
        wr(8'h30, 4'h1, 32'h0000_0001);
        flags(4'h0);
        samp(16'h0FFF, 4'h7);
        rd_chk(8'h20, 32'h0000_0821);
        rd_chk(8'h30, 32'h0000_0002);
        // masking hides a pending event, unmasking shows it, clearing drops it
        wr(8'h34, 4'h1, 32'h0000_0000);
        flags(4'h6);
        wr(8'h34, 4'h1, 32'h0000_0002);
        flags(4'h7);
        wr(8'h30, 4'h1, 32'h0000_0002);
        flags(4'h6);
        samp(16'h1011, 4'h2);
        complete_run();
    end
endmodule
